// [timer_defines.vh]
// register map, field layout, reset values and counts of the timer unit
`ifndef TIMER_DEFINES_VH
`define TIMER_DEFINES_VH

// register indices; byte address on the bus is four times the index
`define IDX_T0_COUNT     6'h01
`define IDX_IRQ_ENABLE   6'h0B
`define IDX_IRQ_FLAGS    6'h0C
`define IDX_T0_RELOAD    6'h10
`define IDX_T0_CTRL      6'h11
`define IDX_T1_COUNT     6'h12
`define IDX_T1_RELOAD    6'h13
`define IDX_T1_CTRL      6'h14
`define IDX_TB_CTRL      6'h15
`define IDX_MISC_CTRL    6'h16
`define IDX_IRQ_CLEAR    6'h20

// interrupt bit positions, shared by flags, enable and clear registers
`define BIT_T0_FLAG      4
`define BIT_T1_FLAG      5
`define BIT_TB_FLAG      6

// first timer control fields
`define BIT_T0_EDGE      5
`define BIT_T0_SRC       4
`define RNG_T0_DIV       3:0

// second timer control field
`define RNG_T1_DIV       3:0
`define BIT_T1_DIV_TOP   3

// time base control fields
`define BIT_TB_SRC       2
`define RNG_TB_INTERVAL  1:0

// halt and clear bits in the shared control register
`define BIT_TB_CLEAR     5
`define BIT_T1_HALT      4
`define BIT_T0_HALT      3

// reset values
`define RST_BYTE         8'h00
`define RST_MISC         8'h20
`define RST_FLAGS        3'h0

// time base interval terminal counts (period minus one)
`define TB_LAST_32768    15'h7FFF
`define TB_LAST_16384    15'h3FFF
`define TB_LAST_8192     15'h1FFF
`define TB_LAST_128      15'h007F

// divider shifts
`define SHIFT_DIV_128    4'h7
`define SHIFT_DIV_512    4'h9
`define COUNT_MAX        8'hFF

`endif

// [pow2_divider.v]
// power-of-two tick divider shared by the three timers
`timescale 1ns/100ps
`default_nettype none

module pow2_divider (
  // clock and reset
  input  wire        clk,
  input  wire        rstn,
  // control
  input  wire        in_tick,
  input  wire [3:0]  shift,
  // result
  output wire        out_tick
);

  reg  [14:0] count;
  wire [15:0] full_mask;
  wire [14:0] mask;

  // divide by two to the shift value; shift 0 passes every tick
  assign full_mask = (16'h0001 << shift) - 16'h0001;
  assign mask      = full_mask[14:0];
  // >= keeps a shrinking divide from waiting a full wrap
  assign out_tick  = in_tick & (count >= mask);

  // count input ticks, restart at terminal
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count <= 15'h0000;
    end else if (in_tick) begin
      if (count >= mask) begin
        count <= 15'h0000;
      end else begin
        count <= count + 15'h0001;
      end
    end
  end

endmodule // pow2_divider

`default_nettype wire

// [triple_timer_unit.v]
// three timers with APB register access and one interrupt output
//
// Operation
// - timer0 source: half clock or count pin
// - count pin edge: 0 rising, 1 falling
// - timer0 divider is two to field value
// - timer1 divides system clock 2..256, 512
// - time base source: slow clock or /128
// - interval codes give 32768/16384/8192/128 clocks
// - time base clear bit holds counter, resets 1
// - timer1 halt bit stops counting, resets 0
// - timer0 halt bit stops counting, resets 0
// - timer0 overflow sets its pending flag
// - timer1 overflow sets its pending flag
// - time base overflow sets its pending flag
// - writing 0 clears flag, 1 leaves it
`timescale 1ns/100ps
`default_nettype none
`include "timer_defines.vh"

module triple_timer_unit (
  // clock and reset
  input  wire        CORE_CLK,
  input  wire        RSTN,
  // apb slave
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [7:0]  PADDR,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output wire        PREADY,
  output wire        PSLVERR,
  // pins
  input  wire        EXTERNAL_COUNT_PIN,
  input  wire        SLOW_CLK,
  // interrupt
  output wire        IRQ
);

  // register storage
  reg  [7:0]  first_timer_reload;
  reg  [7:0]  first_timer_control;
  reg  [7:0]  first_timer_count;
  reg  [7:0]  second_timer_reload;
  reg  [7:0]  second_timer_control;
  reg  [7:0]  second_timer_count;
  reg  [7:0]  timebase_control;
  reg  [7:0]  misc_control;
  reg  [2:0]  irq_enable;
  reg  [2:0]  overflow_flags;
  reg  [14:0] timebase_count;

  // pin synchronisers and edge history
  reg         pin_meta;
  reg         pin_sync;
  reg         pin_last;
  reg         slow_meta;
  reg         slow_sync;
  reg         slow_last;
  reg         half_phase;

  // bus decode
  wire [5:0]  index;
  wire        aligned;
  wire        setup;
  wire        access;
  wire        wr;
  reg         mapped;
  reg  [7:0]  read_byte;

  // control fields
  wire        count_pin_edge_select;
  wire        first_timer_source_select;
  wire [3:0]  first_timer_divider;
  wire [3:0]  second_timer_divider;
  wire        timebase_source_select;
  wire [1:0]  timebase_interval_select;
  wire        timebase_hold_clear;
  wire        second_timer_halt;
  wire        first_timer_halt;

  // tick paths
  wire        pin_rise;
  wire        pin_fall;
  wire        pin_edge;
  wire        first_source_tick;
  wire        first_tick;
  wire [3:0]  second_shift;
  wire        second_tick;
  wire        div128_tick;
  wire        slow_rise;
  wire        timebase_in_tick;
  reg  [14:0] timebase_last;
  wire        first_overflow;
  wire        second_overflow;
  wire        timebase_overflow;
  wire [2:0]  set_flags;
  wire [2:0]  clear_flags;
  wire [2:0]  next_flags;

  // field extraction
  assign count_pin_edge_select     = first_timer_control[`BIT_T0_EDGE];
  assign first_timer_source_select = first_timer_control[`BIT_T0_SRC];
  assign first_timer_divider       = first_timer_control[`RNG_T0_DIV];
  assign second_timer_divider      = second_timer_control[`RNG_T1_DIV];
  assign timebase_source_select    = timebase_control[`BIT_TB_SRC];
  assign timebase_interval_select  = timebase_control[`RNG_TB_INTERVAL];
  assign timebase_hold_clear       = misc_control[`BIT_TB_CLEAR];
  assign second_timer_halt         = misc_control[`BIT_T1_HALT];
  assign first_timer_halt          = misc_control[`BIT_T0_HALT];

  // apb phases; zero wait states, so ready is always high
  assign index   = PADDR[7:2];
  assign aligned = (PADDR[1:0] == 2'b00);
  assign setup   = PSEL & ~PENABLE;
  assign access  = PSEL & PENABLE;
  assign wr      = access & PWRITE & mapped & aligned;
  assign PREADY  = 1'b1;
  assign PSLVERR = access & ~(mapped & aligned);

  // two flops on each pin before any logic, third flop for edges
  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      pin_meta  <= 1'b0;
      pin_sync  <= 1'b0;
      pin_last  <= 1'b0;
      slow_meta <= 1'b0;
      slow_sync <= 1'b0;
      slow_last <= 1'b0;
    end else begin
      pin_meta  <= EXTERNAL_COUNT_PIN;
      pin_sync  <= pin_meta;
      pin_last  <= pin_sync;
      slow_meta <= SLOW_CLK;
      slow_sync <= slow_meta;
      slow_last <= slow_sync;
    end
  end

  // half-rate phase for the first timer's internal source
  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      half_phase <= 1'b0;
    end else begin
      half_phase <= ~half_phase;
    end
  end

  // first timer source: pin edges are only seen after synchronising,
  // so the pin must be slower than a quarter of the system clock
  assign pin_rise  = pin_sync & ~pin_last;
  assign pin_fall  = ~pin_sync & pin_last;
  assign pin_edge  = count_pin_edge_select ? pin_fall : pin_rise;
  assign first_source_tick = (first_timer_source_select ? pin_edge
                              : half_phase) & ~first_timer_halt;

  pow2_divider first_div (
    .clk      (CORE_CLK),
    .rstn     (RSTN),
    .in_tick  (first_source_tick),
    .shift    (first_timer_divider),
    .out_tick (first_tick)
  );

  // second timer: codes 0..7 divide by 2..256, top bit set gives 512
  assign second_shift = second_timer_divider[`BIT_T1_DIV_TOP]
                        ? `SHIFT_DIV_512
                        : {1'b0, second_timer_divider[2:0]} + 4'h1;

  pow2_divider second_div (
    .clk      (CORE_CLK),
    .rstn     (RSTN),
    .in_tick  (~second_timer_halt),
    .shift    (second_shift),
    .out_tick (second_tick)
  );

  // time base source: slow clock rising edges or system clock /128
  pow2_divider timebase_div (
    .clk      (CORE_CLK),
    .rstn     (RSTN),
    .in_tick  (1'b1),
    .shift    (`SHIFT_DIV_128),
    .out_tick (div128_tick)
  );

  assign slow_rise = slow_sync & ~slow_last;
  assign timebase_in_tick = timebase_source_select ? div128_tick
                            : slow_rise;

  // interval selection as a terminal count
  always @* begin
    case (timebase_interval_select)
      2'b00:   timebase_last = `TB_LAST_32768;
      2'b01:   timebase_last = `TB_LAST_16384;
      2'b10:   timebase_last = `TB_LAST_8192;
      2'b11:   timebase_last = `TB_LAST_128;
      default: timebase_last = `TB_LAST_32768;
    endcase
  end

  // overflow events
  assign first_overflow    = first_tick & (first_timer_count == `COUNT_MAX);
  assign second_overflow   = second_tick &
                             (second_timer_count == `COUNT_MAX);
  assign timebase_overflow = timebase_in_tick & ~timebase_hold_clear &
                             (timebase_count >= timebase_last);

  // first timer counter; a bus write overrides a tick in the same cycle
  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      first_timer_count <= `RST_BYTE;
    end else if (wr && index == `IDX_T0_COUNT) begin
      first_timer_count <= PWDATA[7:0];
    end else if (first_overflow) begin
      first_timer_count <= first_timer_reload;
    end else if (first_tick) begin
      first_timer_count <= first_timer_count + 8'h01;
    end
  end

  // second timer counter
  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      second_timer_count <= `RST_BYTE;
    end else if (wr && index == `IDX_T1_COUNT) begin
      second_timer_count <= PWDATA[7:0];
    end else if (second_overflow) begin
      second_timer_count <= second_timer_reload;
    end else if (second_tick) begin
      second_timer_count <= second_timer_count + 8'h01;
    end
  end

  // time base counter, held at zero while the clear bit is set
  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      timebase_count <= 15'h0000;
    end else if (timebase_hold_clear) begin
      timebase_count <= 15'h0000;
    end else if (timebase_overflow) begin
      timebase_count <= 15'h0000;
    end else if (timebase_in_tick) begin
      timebase_count <= timebase_count + 15'h0001;
    end
  end

  // configuration registers
  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      first_timer_reload   <= `RST_BYTE;
      first_timer_control  <= `RST_BYTE;
      second_timer_reload  <= `RST_BYTE;
      second_timer_control <= `RST_BYTE;
      timebase_control     <= `RST_BYTE;
      misc_control         <= `RST_MISC;
      irq_enable           <= `RST_FLAGS;
    end else if (wr) begin
      case (index)
        `IDX_T0_RELOAD:  first_timer_reload   <= PWDATA[7:0];
        `IDX_T0_CTRL:    first_timer_control  <= {2'b00, PWDATA[5:0]};
        `IDX_T1_RELOAD:  second_timer_reload  <= PWDATA[7:0];
        `IDX_T1_CTRL:    second_timer_control <= {4'h0, PWDATA[3:0]};
        `IDX_TB_CTRL:    timebase_control     <= {5'h00, PWDATA[2:0]};
        `IDX_MISC_CTRL:  misc_control         <= {2'b00, PWDATA[5:3],
                                                  3'b000};
        `IDX_IRQ_ENABLE: irq_enable <= PWDATA[`BIT_TB_FLAG:`BIT_T0_FLAG];
        default:         irq_enable <= irq_enable;
      endcase
    end
  end

  // pending flags: write 0 to the flag register or 1 to the clear
  // register; an overflow in the same cycle wins over the clear
  assign set_flags   = {timebase_overflow,
                        second_overflow,
                        first_overflow};
  assign clear_flags =
    ({3{wr && index == `IDX_IRQ_FLAGS}} &
     ~PWDATA[`BIT_TB_FLAG:`BIT_T0_FLAG]) |
    ({3{wr && index == `IDX_IRQ_CLEAR}} &
     PWDATA[`BIT_TB_FLAG:`BIT_T0_FLAG]);
  assign next_flags  = (overflow_flags & ~clear_flags) | set_flags;

  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      overflow_flags <= `RST_FLAGS;
    end else begin
      overflow_flags <= next_flags;
    end
  end

  // level interrupt while any enabled flag is pending
  assign IRQ = |(overflow_flags & irq_enable);

  // address decode and read mux
  always @* begin
    mapped    = 1'b1;
    read_byte = 8'h00;
    case (index)
      `IDX_T0_COUNT:   read_byte = first_timer_count;
      `IDX_IRQ_ENABLE: read_byte = {1'b0, irq_enable, 4'h0};
      `IDX_IRQ_FLAGS:  read_byte = {1'b0, overflow_flags, 4'h0};
      `IDX_T0_RELOAD:  read_byte = first_timer_reload;
      `IDX_T0_CTRL:    read_byte = first_timer_control;
      `IDX_T1_COUNT:   read_byte = second_timer_count;
      `IDX_T1_RELOAD:  read_byte = second_timer_reload;
      `IDX_T1_CTRL:    read_byte = second_timer_control;
      `IDX_TB_CTRL:    read_byte = timebase_control;
      `IDX_MISC_CTRL:  read_byte = misc_control;
      `IDX_IRQ_CLEAR:  read_byte = 8'h00;  // write-only
      default:         mapped    = 1'b0;
    endcase
  end

  // read data captured in the setup cycle, held through the access
  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      PRDATA <= 32'h00000000;
    end else if (setup && !PWRITE) begin
      PRDATA <= (mapped && aligned) ? {24'h000000, read_byte}
                                    : 32'h00000000;
    end
  end

endmodule // triple_timer_unit

`default_nettype wire

// [timer_unit_chk.sv]
// port checker for the triple timer unit, bound to its top module
`timescale 1ns/100ps
`default_nettype none

module timer_unit_chk (
  // clock and reset
  input wire logic        CORE_CLK,
  input wire logic        RSTN,
  // bus
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  // pins and interrupt
  input wire logic        EXTERNAL_COUNT_PIN,
  input wire logic        SLOW_CLK,
  input wire logic        IRQ
);
  default clocking @(posedge CORE_CLK);
  endclocking
  default disable iff (!RSTN);

  // address decode; a hole in the map must answer with an error
  wire [5:0] idx = PADDR[7:2];
  wire       hit = PADDR[1:0] == 2'h0 && (idx == 6'h01 ||
    idx == 6'h0B || idx == 6'h0C || idx == 6'h20 ||
    (idx >= 6'h10 && idx <= 6'h16));
  wire       rds = PSEL && !PENABLE && !PWRITE;
  wire       wra = PSEL && PENABLE && PWRITE;

  a_ready_high: assert property (PREADY)
    else $error("ready low");
  a_error_flag: assert property (PSLVERR == (PSEL && PENABLE && !hit))
    else $error("error flag wrong");
  a_hole_reads: assert property (rds && !hit |=> PRDATA == 32'h0)
    else $error("hole read not zero");
  a_upper_zero: assert property (PRDATA[31:8] == 24'h0)
    else $error("upper read data set");
  a_data_stands: assert property (!rds |=> $stable(PRDATA))
    else $error("read data moved");
  a_flag_layout: assert property (rds && PADDR == 8'h30 |=>
    (PRDATA[7:0] & 8'h8F) == 8'h00)
    else $error("flag read layout");
  a_misc_layout: assert property (rds && PADDR == 8'h58 |=>
    (PRDATA[7:0] & 8'hC7) == 8'h00)
    else $error("misc read layout");
  a_mask_drops: assert property (wra && PADDR == 8'h2C &&
    PWDATA[6:4] == 3'h0 |=> !IRQ)
    else $error("irq kept when masked");
  a_ones_keep: assert property (wra && PADDR == 8'h30 &&
    PWDATA[6:4] == 3'h7 && IRQ |=> IRQ)
    else $error("writing ones dropped a flag");
  a_quiet_start: assert property ($rose(RSTN) |-> !IRQ)
    else $error("irq after reset");
endmodule // timer_unit_chk

bind triple_timer_unit timer_unit_chk timer_unit_chk_i (
  .CORE_CLK(CORE_CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .SLOW_CLK(SLOW_CLK), .IRQ(IRQ),
  .EXTERNAL_COUNT_PIN(EXTERNAL_COUNT_PIN));

`default_nettype wire

// [triple_timer_unit_tb_top.sv]
// self-checking bench for the triple timer unit
`timescale 1ns/100ps
`default_nettype none

module triple_timer_unit_tb_top;
  // bench signals, all but rd and err given a value at time zero
  logic        clk = 1'b0, rstn = 1'b0, psel = 1'b0, pen = 1'b0;
  logic        pwr = 1'b0, pin = 1'b0, slow = 1'b0, err;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwd = 32'h0, rd;
  wire  [31:0] prd;
  wire         prdy, perr, irq;
  int          miscompares, cmp_count, cyc;
  // configuration places; the counts move at once so are left out
  logic [5:0]  ri [9] = '{6'h0B, 6'h0C, 6'h10, 6'h11, 6'h13, 6'h14,
                          6'h15, 6'h16, 6'h20};

  triple_timer_unit triple_timer_unit_i (
    .CORE_CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwd), .PRDATA(prd),
    .PREADY(prdy), .PSLVERR(perr), .EXTERNAL_COUNT_PIN(pin),
    .SLOW_CLK(slow), .IRQ(irq));

  initial begin
    forever #5 clk = ~clk;
  end

  // slow clock at half the core rate keeps long intervals short; hang guard
  always @(posedge clk) begin
    cyc  <= cyc + 1;
    slow <= cyc[0];
    if (cyc == 90000) begin
      miscompares++;
      end_of_test();
    end
  end

  // one bus transfer; waits for ready, takes data and error there
  task automatic xfer(input logic w, input logic [5:0] i,
                      input logic [7:0] d);
    @(posedge clk);
    psel  <= 1'b1;
    pen   <= 1'b0;
    pwr   <= w;
    paddr <= {i, 2'h0};
    pwd   <= {24'h0, d};
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (prdy !== 1'b1);
    rd  = prd;
    err = perr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // range compare; phase of the dividers leaves a little slack
  task automatic rng(input logic [7:0] lo, input logic [7:0] hi);
    cmp_count++;
    if ((rd[7:0] >= lo && rd[7:0] <= hi) !== 1'b1) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h..%h",
               $time, rd[7:0], lo, hi);
    end
  endtask

  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    xfer(1'b1, i, d);
  endtask

  task automatic rdc(input logic [5:0] i, input logic [7:0] e);
    xfer(1'b0, i, 8'h00);
    chk(rd, {24'h0, e});
  endtask

  // eight periods of a divider should give about eight counts
  task automatic rate(input logic [5:0] ci, ki, input logic [7:0] c,
                      input int per);
    wr(ci, c);
    wr(ki, 8'h00);
    repeat (8 * per) @(posedge clk);
    xfer(1'b0, ki, 8'h00);
    rng(8'h07, 8'h0A);
  endtask

  // time base held, then released; no flag before a, flag after b
  task automatic t2(input logic [7:0] c, input int a, input int b);
    wr(6'h15, c);
    wr(6'h16, 8'h38);
    wr(6'h0C, 8'h00);
    repeat (600) @(posedge clk);
    rdc(6'h0C, 8'h00);
    wr(6'h16, 8'h18);
    repeat (a) @(posedge clk);
    rdc(6'h0C, 8'h00);
    repeat (b) @(posedge clk);
    rdc(6'h0C, 8'h40);
  endtask

  task automatic end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    foreach (ri[k]) rdc(ri[k], ri[k] == 6'h16 ? 8'h20 : 8'h00);
    // a hole in the map answers with an error and zero data
    xfer(1'b0, 6'h3F, 8'h00);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    wr(6'h10, 8'hA5);
    rdc(6'h10, 8'hA5);
    // both timers halted: counts keep what software wrote
    wr(6'h16, 8'h38);
    wr(6'h01, 8'h80);
    wr(6'h12, 8'h81);
    repeat (50) @(posedge clk);
    rdc(6'h01, 8'h80);
    rdc(6'h12, 8'h81);
    wr(6'h16, 8'h20);
    for (int c = 0; c < 8; c++) rate(6'h14, 6'h12, c[7:0], 2 << c);
    rate(6'h14, 6'h12, 8'h0F, 512);
    for (int c = 0; c < 8; c += 3) rate(6'h11, 6'h01, c[7:0], 2 << c);
    // timer1 wraps to its reload value and raises its flag
    wr(6'h16, 8'h28);
    wr(6'h14, 8'h00);
    wr(6'h13, 8'hF0);
    wr(6'h0C, 8'h00);
    wr(6'h12, 8'hFE);
    repeat (20) @(posedge clk);
    xfer(1'b0, 6'h12, 8'h00);
    rng(8'hF7, 8'hFA);
    wr(6'h16, 8'h38);
    rdc(6'h0C, 8'h20);
    wr(6'h0B, 8'h20);
    #1 chk(irq, 1'b1);
    wr(6'h0C, 8'hFF);
    rdc(6'h0C, 8'h20);
    wr(6'h0B, 8'h00);
    #1 chk(irq, 1'b0);
    wr(6'h0B, 8'h20);
    wr(6'h20, 8'h20);
    rdc(6'h0C, 8'h00);
    #1 chk(irq, 1'b0);
    // timer0 counts the pin on the chosen edge only
    wr(6'h10, 8'h33);
    wr(6'h16, 8'h30);
    for (int e = 0; e < 2; e++) begin
      wr(6'h11, e ? 8'h30 : 8'h10);
      wr(6'h01, 8'hFF);
      pin <= 1'b1;
      repeat (8) @(posedge clk);
      rdc(6'h01, e ? 8'hFF : 8'h33);
      pin <= 1'b0;
      repeat (8) @(posedge clk);
      rdc(6'h01, 8'h33);
    end
    rdc(6'h0C, 8'h10);
    wr(6'h0C, 8'h00);
    rdc(6'h0C, 8'h00);
    // time base: slow clock intervals, then the divided core clock
    t2(8'h03, 220, 100);
    t2(8'h01, 32000, 1500);
    t2(8'h02, 15800, 1200);
    t2(8'h07, 15500, 1500);
    wr(6'h0B, 8'h40);
    #1 chk(irq, 1'b1);
    end_of_test();
  end
endmodule // triple_timer_unit_tb_top

`default_nettype wire
